// File: bench/dual_8bit_compare_timer_tb.sv
/* self-checking bench for tmh_dual_timer: reads compared through a queue,
   periods measured at the match interrupts, pwm widths at the pins. assumes the checker is bound. */
module dual_8bit_compare_timer_tb
    import tmh_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic oto = 1'b0;
    logic slow = 1'b0;
    tmh_bus_req_s req = '0;
    logic [7:0] rdata, v;
    logic [1:0] pin, irq;
    logic [7:0] exp_q[$];
    logic rd_d = 1'b0;
    logic [15:0] addrs[6] = '{ADDR_CYCLE0, ADDR_DUTY0, ADDR_CYCLE1, ADDR_DUTY1, ADDR_MODE0, ADDR_MODE1};
    int shift[6] = '{0, 1, 2, 6, 10, 1};
    int seed = 32'h002e;
    int error_cnt = 0;
    int n_tests = 0;
    int n;
    int k;
    tmh_dual_timer i_tmh_dual_timer (.clk(clk), .resetn(resetn), .bus_req(req), .bus_rdata(rdata),
        .other_timer_output(oto), .slow_osc_tick(slow), .timer_output_pin(pin),
        .timer_match_irq(irq));
    always #50 clk = ~clk;
    // other timer as a square wave: one rising edge every two cycles
    always @(posedge clk) begin
        oto <= ~oto;
        slow <= ($random(seed) & 3) == 0;
    end
    task automatic check(input logic [19:0] got, input logic [19:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
        end
    endtask
    always @(posedge clk) begin
        if (rd_d) begin
            check({12'h000, rdata}, {12'h000, exp_q.pop_front()}, "read");
        end
        rd_d = req.rd;
    end
    task automatic op(input logic w, b, r, input logic [2:0] s, input logic [15:0] a,
                      input logic [7:0] d);
        @(posedge clk);
        req <= {w, b, r, s, a, d};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        op(1'b1, 1'b0, 1'b0, 3'h0, a, d);
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        op(1'b0, 1'b0, 1'b1, 3'h0, a, 8'h00);
    endtask
    task automatic wait_irq(input int u);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (irq[u] !== 1'b1 && n < 30000);
    endtask
    // first match after a change may carry old prescaler phase
    task automatic period(input int u, input logic [19:0] exp);
        wait_irq(u);
        wait_irq(u);
        wait_irq(u);
        check(n[19:0], exp, "period");
    endtask
    task automatic until_pin(input int u, input logic lv);
        n = 0;
        while (pin[u] !== lv && n < 3000) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #(60000 * 100);
        error_cnt++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        foreach (addrs[i]) rd(addrs[i], 8'h00);
        rd(16'h1234, 8'h00);
        foreach (addrs[i]) begin
            v = $random(seed);
            if (i > 3) v[RUN_BIT] = 1'b0;
            wr(addrs[i], v);
            rd(addrs[i], v);
        end
        wr(ADDR_MODE0, 8'h00);
        op(1'b0, 1'b1, 1'b0, 3'h1, ADDR_MODE0, 8'h01);
        rd(ADDR_MODE0, 8'h02);
        for (int c = 0; c < 6; c++) begin
            v = ($random(seed) & 3) + 1;
            wr(ADDR_CYCLE0, v);
            wr(ADDR_MODE0, {1'b1, c[2:0], MODE_INTERVAL, 2'b01});
            period(0, ({12'h000, v} + 20'h00001) << shift[c]);
            wr(ADDR_MODE0, {1'b0, c[2:0], MODE_INTERVAL, 2'b01});
        end
        wr(ADDR_CYCLE1, 8'h02);
        wr(ADDR_MODE1, 8'h10);
        op(1'b0, 1'b1, 1'b0, 3'h7, ADDR_MODE1, 8'h01);
        period(1, 20'd12);
        op(1'b0, 1'b1, 1'b0, 3'h7, ADDR_MODE1, 8'h00);
        wr(ADDR_CYCLE0, 8'h09);
        wr(ADDR_DUTY0, 8'h03);
        wr(ADDR_MODE0, 8'h89);
        until_pin(0, 1'b0);
        until_pin(0, 1'b1);
        until_pin(0, 1'b0);
        check(n[19:0], 20'd4, "pwm width");
        wr(ADDR_DUTY0, 8'h06);
        rd(ADDR_DUTY0, 8'h06);
        until_pin(0, 1'b1);
        until_pin(0, 1'b0);
        until_pin(0, 1'b1);
        until_pin(0, 1'b0);
        check(n[19:0], 20'd7, "pwm width after update");
        // second write lands on the duty match edge, so the pending load is skipped
        wr(ADDR_DUTY0, 8'h02);
        repeat (4) @(posedge clk);
        wr(ADDR_DUTY0, 8'h04);
        until_pin(0, 1'b0);
        until_pin(0, 1'b1);
        until_pin(0, 1'b0);
        check(n[19:0], 20'd7, "pwm width after collision");
        until_pin(0, 1'b1);
        until_pin(0, 1'b0);
        check(n[19:0], 20'd5, "pwm width after late load");
        wr(ADDR_MODE0, 8'h09);
        // prohibited clock code must give no ticks
        wr(ADDR_MODE0, {1'b1, 3'h6, MODE_INTERVAL, 2'b01});
        n = 0;
        repeat (200) begin
            @(posedge clk);
            if (irq[0] !== 1'b0) begin
                n++;
            end
        end
        check(n[19:0], 20'd0, "irq from prohibited clock code");
        wr(ADDR_MODE0, {1'b0, 3'h6, MODE_INTERVAL, 2'b01});
        wr(ADDR_CYCLE1, 8'h02);
        wr(ADDR_DUTY1, 8'h04);
        wr(ADDR_MODE1, 8'h85);
        period(1, 20'd8);
        until_pin(1, 1'b0);
        until_pin(1, 1'b1);
        until_pin(1, 1'b0);
        check(n[19:0], 20'd5, "carrier duty phase width");
        op(1'b0, 1'b1, 1'b0, 3'h7, ADDR_MODE1, 8'h00);
        // unit 1 on the slow tick: count the pulses the design sees in one period
        wr(ADDR_CYCLE1, 8'h03);
        wr(ADDR_MODE1, 8'hd0);
        wait_irq(1);
        k = slow;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (irq[1] !== 1'b1) begin
                k += slow;
            end
        end while (irq[1] !== 1'b1 && n < 3000);
        check(k[19:0], 20'd4, "slow tick period");
        @(posedge clk);
        conclude();
    end
endmodule

// File: bench/tmh_dual_timer_checker.sv
/* checker for tmh_dual_timer: bus read timing and unit 0 timer behaviour at the ports.
   assumes the bench never writes a register in the cycle of a read. */
module tmh_dual_timer_checker
    import tmh_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // bus and outputs
    input wire tmh_bus_req_s bus_req,
    input wire logic [7:0] bus_rdata,
    input wire logic [1:0] timer_output_pin,
    input wire logic [1:0] timer_match_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] m0_r, c0_r;
    logic [19:0] gap_r;
    logic [1:0] arm_r;
    logic [3:0] ex;
    logic wm, stop;
    assign wm = (bus_req.wr || bus_req.bit_wr) && bus_req.addr inside {ADDR_MODE0, ADDR_CYCLE0};
    // level kept, so the default level after stopping is unambiguous
    assign stop = bus_req.wr && bus_req.addr == ADDR_MODE0 && !bus_req.wdata[RUN_BIT]
        && bus_req.wdata[LEVEL_BIT] == m0_r[LEVEL_BIT];
    assign ex = (m0_r[6:4] == 3'h3) ? 4'h6 : (m0_r[6:4] == 3'h4) ? 4'ha : {1'b0, m0_r[6:4]};
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            m0_r <= 8'h00;
            c0_r <= 8'h00;
        end else if (bus_req.wr && bus_req.addr == ADDR_MODE0) begin
            m0_r <= bus_req.wdata;
        end else if (bus_req.wr && bus_req.addr == ADDR_CYCLE0) begin
            c0_r <= bus_req.wdata;
        end else if (bus_req.bit_wr && bus_req.addr == ADDR_MODE0) begin
            m0_r[bus_req.bit_sel] <= bus_req.wdata[0];
        end
    end
    // prescaler phase is unknown after a change: trust matches from the third one on
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gap_r <= 20'h00001;
            arm_r <= 2'h0;
        end else if (wm) begin
            arm_r <= 2'h0;
        end else if (timer_match_irq[0]) begin
            gap_r <= 20'h00001;
            arm_r <= (arm_r == 2'h2) ? 2'h2 : arm_r + 2'h1;
        end else begin
            gap_r <= gap_r + 20'h00001;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    AST_MODE_RD: assert property (bus_req.rd && bus_req.addr == ADDR_MODE0 |=> bus_rdata == m0_r)
        else $error("mode read mismatch");
    AST_CYC_RD: assert property (bus_req.rd && bus_req.addr == ADDR_CYCLE0 |=> bus_rdata == c0_r)
        else $error("cycle compare read mismatch");
    AST_RD_HOLD: assert property (!bus_req.rd |=> $stable(bus_rdata))
        else $error("read data moved without a read");
    AST_RD_UNMAPPED: assert property (bus_req.rd && bus_req.addr[15:8] != 8'hff |=> bus_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_PERIOD: assert property (timer_match_irq[0] && arm_r == 2'h2 && m0_r[7] &&
        m0_r[3:2] == MODE_INTERVAL && m0_r[6:4] < CKS_EXT |-> gap_r == ({12'h000, c0_r} + 20'h1) << ex)
        else $error("interval period wrong");
    // pin sits one flop behind the output flip-flop, so it moves a cycle after the pulse
    AST_TOGGLE: assert property (timer_match_irq[0] && arm_r == 2'h2 && m0_r[7] &&
        m0_r[3:2] == MODE_INTERVAL && m0_r[0] |=> timer_output_pin[0] != $past(timer_output_pin[0]))
        else $error("output did not invert at match");
    AST_STOP_IRQ: assert property (stop |=> ##1 !timer_match_irq[0])
        else $error("interrupt after stop");
    AST_STOP_PIN: assert property (stop |=> ##2 timer_output_pin[0] == $past(bus_req.wdata[1], 3))
        else $error("output not at default level after stop");
    AST_IDLE_IRQ: assert property (!$past(m0_r[RUN_BIT]) |-> !timer_match_irq[0])
        else $error("interrupt while stopped");
endmodule
bind tmh_dual_timer tmh_dual_timer_checker i_tmh_dual_timer_checker (.clk(clk), .resetn(resetn),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .timer_output_pin(timer_output_pin),
    .timer_match_irq(timer_match_irq));

// File: core/tmh_dual_timer.sv
/*
 * tmh_dual_timer: two 8-bit compare timers with cycle and duty compares,
 * mode registers and timer output pins, on the internal register bus.
 * assumes bus requests, the other timer's output and the slow tick all come
 * from logic on clk; the bit-write form touches only the mode registers.
 */
module tmh_dual_timer
    import tmh_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register bus
    input wire tmh_bus_req_s bus_req,
    output logic [7:0] bus_rdata,
    // count sources from neighbouring logic
    input wire logic other_timer_output,
    input wire logic slow_osc_tick,
    // timer outputs
    output logic [1:0] timer_output_pin,
    output logic [1:0] timer_match_irq
);
    logic [DIV_W-1:0] div_cnt_r;
    logic other_timer_d_r;
    logic other_edge;
    logic [7:0] cycle_compare_r [2];
    logic [7:0] duty_compare_r [2];
    logic [7:0] duty_act_r [2];
    logic [7:0] mode_control_r [2];
    logic [7:0] count_r [2];
    logic [1:0] out_ff_r;
    logic [1:0] carrier_phase_r;
    logic [1:0] irq_r;
    logic [7:0] rdata_r;

    function automatic logic pow_tick(input logic [DIV_W-1:0] cnt, input logic [3:0] e);
        logic [DIV_W-1:0] mask;
        mask = DIV_W'((DIV_W'(1) << e) - DIV_W'(1));
        return (cnt & mask) == mask;
    endfunction

    // count-clock select; codes 110 and 111 give no tick at all
    function automatic logic sel_tick(input logic unit, input logic [2:0] cks,
            input logic [DIV_W-1:0] cnt, input logic ext0, input logic ext1);
        logic t;
        t = 1'b0;
        unique case (cks)
            3'h0: t = pow_tick(cnt, unit ? U1_EXP0 : U0_EXP0);
            3'h1: t = pow_tick(cnt, unit ? U1_EXP1 : U0_EXP1);
            3'h2: t = pow_tick(cnt, unit ? U1_EXP2 : U0_EXP2);
            3'h3: t = pow_tick(cnt, unit ? U1_EXP3 : U0_EXP3);
            3'h4: t = pow_tick(cnt, unit ? U1_EXP4 : U0_EXP4);
            CKS_EXT: t = unit ? ext1 : ext0;
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    // free-running prescaler
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_cnt_r <= '0;
        end else begin
            div_cnt_r <= DIV_W'(div_cnt_r + DIV_W'(1));
        end
    end

    // other timer output edge; its pin enable is never consulted
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            other_timer_d_r <= 1'b0;
        end else begin
            other_timer_d_r <= other_timer_output;
        end
    end
    assign other_edge = other_timer_output & ~other_timer_d_r;

    for (genvar u = 0; u < 2; u++) begin : g_unit
        localparam logic [15:0] A_CYC = (u == 0) ? ADDR_CYCLE0 : ADDR_CYCLE1;
        localparam logic [15:0] A_DUTY = (u == 0) ? ADDR_DUTY0 : ADDR_DUTY1;
        localparam logic [15:0] A_MODE = (u == 0) ? ADDR_MODE0 : ADDR_MODE1;
        logic run;
        logic tick;
        logic [1:0] mode;
        logic is_pwm;
        logic is_car;
        logic cyc_hit;
        logic duty_hit;
        logic duty_wr;
        logic [7:0] cmp_now;

        assign run = mode_control_r[u][RUN_BIT];
        assign mode = mode_control_r[u][MODE_LSB+1:MODE_LSB];
        assign is_pwm = (mode == MODE_PWM);
        assign is_car = (u == 1) && (mode == MODE_CARRIER);
        assign tick = run && sel_tick(1'(u), mode_control_r[u][CKS_LSB+2:CKS_LSB],
            div_cnt_r, other_edge, slow_osc_tick);
        // carrier mode alternates between cycle phase and duty phase
        assign cmp_now = (is_car && carrier_phase_r[u]) ? duty_act_r[u]
                                                          : cycle_compare_r[u];
        assign cyc_hit = tick && (count_r[u] == cmp_now) && !(is_car && carrier_phase_r[u]);
        assign duty_hit = tick && (count_r[u] == duty_act_r[u])
            && (is_pwm || (is_car && carrier_phase_r[u]));
        assign duty_wr = bus_req.wr && (bus_req.addr == A_DUTY);

        // cycle compare; never touched by the counter side
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                cycle_compare_r[u] <= CYCLE_RST;
            end else if (bus_req.wr && bus_req.addr == A_CYC) begin
                cycle_compare_r[u] <= bus_req.wdata;
            end
        end

        // duty compare: software copy and the active copy used for matching
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                duty_compare_r[u] <= DUTY_RST;
                duty_act_r[u] <= DUTY_RST;
            end else begin
                if (duty_wr) begin
                    duty_compare_r[u] <= bus_req.wdata;
                end
                if (duty_wr && !run) begin
                    duty_act_r[u] <= bus_req.wdata;
                end else if (duty_hit && !duty_wr) begin
                    duty_act_r[u] <= duty_compare_r[u];
                end
            end
        end

        // mode register; bit form is read-modify-write done here
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                mode_control_r[u] <= MODE_RST;
            end else if (bus_req.addr == A_MODE) begin
                if (bus_req.wr) begin
                    mode_control_r[u] <= bus_req.wdata;
                end else if (bus_req.bit_wr) begin
                    mode_control_r[u][bus_req.bit_sel] <= bus_req.wdata[0];
                end
            end
        end

        // counter
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                count_r[u] <= 8'h00;
            end else if (!run) begin
                count_r[u] <= 8'h00;
            end else if (cyc_hit || (is_car && duty_hit)) begin
                count_r[u] <= 8'h00;
            end else if (tick) begin
                count_r[u] <= 8'(count_r[u] + 8'h01);
            end
        end

        // carrier phase, only meaningful on unit 1
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                carrier_phase_r[u] <= 1'b0;
            end else if (!run || !is_car) begin
                carrier_phase_r[u] <= 1'b0;
            end else if (cyc_hit || duty_hit) begin
                carrier_phase_r[u] <= ~carrier_phase_r[u];
            end
        end

        // output flip-flop; the inactive level is the default level
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                out_ff_r[u] <= 1'b0;
            end else if (!run) begin
                out_ff_r[u] <= mode_control_r[u][LEVEL_BIT];
            end else if (is_pwm) begin
                if (cyc_hit) begin
                    out_ff_r[u] <= ~mode_control_r[u][LEVEL_BIT];
                end else if (duty_hit) begin
                    out_ff_r[u] <= mode_control_r[u][LEVEL_BIT];
                end
            end else if (cyc_hit || duty_hit) begin
                out_ff_r[u] <= ~out_ff_r[u];
            end
        end

        // interrupt pulse; interval and PWM on cycle match, carrier on duty match
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                irq_r[u] <= 1'b0;
            end else if (!run) begin
                irq_r[u] <= 1'b0;
            end else begin
                irq_r[u] <= is_car ? duty_hit : cyc_hit;
            end
        end

        // disabled output parks at the default level rather than floating
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                timer_output_pin[u] <= 1'b0;
            end else begin
                timer_output_pin[u] <= mode_control_r[u][OUTEN_BIT] ? out_ff_r[u]
                                                  : mode_control_r[u][LEVEL_BIT];
            end
        end
    end

    assign timer_match_irq = irq_r;

    // read port, one cycle latency; unmapped addresses read zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_r <= 8'h00;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                ADDR_CYCLE0: rdata_r <= cycle_compare_r[0];
                ADDR_DUTY0: rdata_r <= duty_compare_r[0];
                ADDR_CYCLE1: rdata_r <= cycle_compare_r[1];
                ADDR_DUTY1: rdata_r <= duty_compare_r[1];
                ADDR_MODE0: rdata_r <= mode_control_r[0];
                ADDR_MODE1: rdata_r <= mode_control_r[1];
                default: rdata_r <= 8'h00;
            endcase
        end
    end
    assign bus_rdata = rdata_r;
endmodule

// File: core/tmh_pkg.sv
/*
 * tmh_pkg: constants and the bus request type for the dual 8-bit compare timer.
 * assumes a single 10 MHz system clock and an 8-bit internal register bus.
 */
package tmh_pkg;
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DIV_W = 12;

    // register addresses
    localparam logic [15:0] ADDR_CYCLE0 = 16'hff18;
    localparam logic [15:0] ADDR_DUTY0 = 16'hff19;
    localparam logic [15:0] ADDR_CYCLE1 = 16'hff1a;
    localparam logic [15:0] ADDR_DUTY1 = 16'hff1b;
    localparam logic [15:0] ADDR_MODE0 = 16'hff69;
    localparam logic [15:0] ADDR_MODE1 = 16'hff6c;

    // reset values
    localparam logic [7:0] CYCLE_RST = 8'h00;
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;

    // mode register fields
    localparam int unsigned RUN_BIT = 7;
    localparam int unsigned CKS_LSB = 4;
    localparam int unsigned MODE_LSB = 2;
    localparam int unsigned LEVEL_BIT = 1;
    localparam int unsigned OUTEN_BIT = 0;

    // operating modes
    localparam logic [1:0] MODE_INTERVAL = 2'h0;
    localparam logic [1:0] MODE_CARRIER = 2'h1;
    localparam logic [1:0] MODE_PWM = 2'h2;

    // count-clock codes and prescaler exponents
    localparam logic [2:0] CKS_EXT = 3'h5;
    localparam logic [3:0] U0_EXP0 = 4'h0;
    localparam logic [3:0] U0_EXP1 = 4'h1;
    localparam logic [3:0] U0_EXP2 = 4'h2;
    localparam logic [3:0] U0_EXP3 = 4'h6;
    localparam logic [3:0] U0_EXP4 = 4'ha;
    localparam logic [3:0] U1_EXP0 = 4'h0;
    localparam logic [3:0] U1_EXP1 = 4'h2;
    localparam logic [3:0] U1_EXP2 = 4'h4;
    localparam logic [3:0] U1_EXP3 = 4'h6;
    localparam logic [3:0] U1_EXP4 = 4'hc;

    typedef struct packed {
        logic wr;
        logic bit_wr;
        logic rd;
        logic [2:0] bit_sel;
        logic [15:0] addr;
        logic [7:0] wdata;
    } tmh_bus_req_s;
endpackage
